/* File: ardr_ramp.sv */
// Added by the designer: strobed register access and the address map.
`timescale 1ns/1ps
// Summary of operation
// - accel slope is reference over accel time
// - decel slope is reference over decel time
// - reference frequency 1..400 Hz, default 60
// - ramp times accepted from 0 to 3600 s
// - select asserted uses second ramp times
// - second decel 9999 follows second accel
// - S-pattern A times are to base frequency
// - S-pattern A above base follows quadratic law
// - times 0.03 s or less become 0.04 s
// - reference change keeps gain frequencies
// - select also enables other second functions
// - longer time gives proportionally slower ramp
// - pattern 0 linear, 1 S-A, 2 S-B; code 2 is stored but ramps as linear
module ardr_ramp #(
	parameter int TICK_CYCLES = ardr_pkg::TICK_CYCLES
) (
	// clock and reset
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	// register port
	input wire logic [ardr_pkg::ADDR_W-1:0] addr_in,
	input wire logic [ardr_pkg::DATA_W-1:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [ardr_pkg::DATA_W-1:0] rdata_out,
	// terminal input
	input wire logic second_set_select_in,
	// ramp outputs
	output logic [ardr_pkg::FREQ_W-1:0] output_frequency_out,
	output logic second_function_active_out,
	output logic ramp_busy_out
);
	localparam int TW = ardr_pkg::TIME_W;
	localparam int FW = ardr_pkg::FREQ_W;
	localparam int DW = ardr_pkg::DIV_W;
	localparam int AW = FW + ardr_pkg::FRAC_W;

	logic [TW-1:0] accel_time_setting;
	logic [TW-1:0] decel_time_setting;
	logic [TW-1:0] second_accel_time_setting;
	logic [TW-1:0] second_decel_time_setting;
	logic [FW-1:0] ramp_reference_frequency;
	logic [FW-1:0] base_frequency_setting;
	logic [ardr_pkg::PATTERN_W-1:0] ramp_pattern_select;
	logic [FW-1:0] gain_frequency_input_a;
	logic [FW-1:0] gain_frequency_input_b;
	logic [FW-1:0] target_frequency;
	logic [AW-1:0] freq_acc;
	logic sel_s1;
	logic sel_s2;
	logic sel_s3;
	logic second_set_select;
	logic [$clog2(TICK_CYCLES)-1:0] tick_cnt;
	logic tick;
	ardr_pkg::ardr_state_t state;
	logic ramp_up;
	logic div_start;
	logic div_done;
	logic [DW-1:0] div_num;
	logic [DW-1:0] div_den;
	logic [DW-1:0] div_quot;
	logic [TW-1:0] sel_accel;
	logic [TW-1:0] sel_decel;
	logic [TW-1:0] raw_time;
	logic [TW-1:0] eff_time;
	logic [FW-1:0] out_freq;
	logic [AW-1:0] target_acc;
	logic [AW-1:0] step;
	logic [AW:0] next_up;
	logic [AW:0] next_down;

	function automatic logic [TW-1:0] clamp_time(input logic [DW-1:0] v);
		clamp_time = (v > DW'(ardr_pkg::TIME_MAX)) ? ardr_pkg::TIME_MAX : v[TW-1:0];
	endfunction

	assign out_freq = freq_acc[AW-1:ardr_pkg::FRAC_W];
	assign target_acc = {target_frequency, {ardr_pkg::FRAC_W{1'b0}}};

	// terminal select: three stages, takes the third stage level when second and third agree
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			sel_s1 <= 1'b0;
			sel_s2 <= 1'b0;
			sel_s3 <= 1'b0;
			second_set_select <= 1'b0;
		end else if (ce_in) begin
			sel_s1 <= second_set_select_in;
			sel_s2 <= sel_s1;
			sel_s3 <= sel_s2;
			if (sel_s2 == sel_s3) begin
				second_set_select <= sel_s3;
			end
		end
	end

	assign second_function_active_out = second_set_select;

	// settings registers
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			accel_time_setting <= ardr_pkg::TIME_RST;
			decel_time_setting <= ardr_pkg::TIME_RST;
			second_accel_time_setting <= ardr_pkg::TIME_RST;
			second_decel_time_setting <= ardr_pkg::SECOND_DECEL_FOLLOW;
			ramp_reference_frequency <= ardr_pkg::REF_FREQ_RST;
			base_frequency_setting <= ardr_pkg::BASE_FREQ_RST;
			ramp_pattern_select <= ardr_pkg::PATTERN_RST;
			gain_frequency_input_a <= ardr_pkg::GAIN_FREQ_RST;
			gain_frequency_input_b <= ardr_pkg::GAIN_FREQ_RST;
			target_frequency <= ardr_pkg::TARGET_FREQ_RST;
		end else if (ce_in && wr_in) begin
			if (addr_in == ardr_pkg::ACCEL_TIME_OFS) begin
				accel_time_setting <= clamp_time(DW'(wdata_in));
			end else if (addr_in == ardr_pkg::DECEL_TIME_OFS) begin
				decel_time_setting <= clamp_time(DW'(wdata_in));
			end else if (addr_in == ardr_pkg::REF_FREQ_OFS) begin
				// gain frequencies are deliberately left alone here
				if (wdata_in < 32'(ardr_pkg::REF_FREQ_MIN)) begin
					ramp_reference_frequency <= ardr_pkg::REF_FREQ_MIN;
				end else if (wdata_in > 32'(ardr_pkg::REF_FREQ_MAX)) begin
					ramp_reference_frequency <= ardr_pkg::REF_FREQ_MAX;
				end else begin
					ramp_reference_frequency <= wdata_in[FW-1:0];
				end
			end else if (addr_in == ardr_pkg::SECOND_ACCEL_OFS) begin
				second_accel_time_setting <= clamp_time(DW'(wdata_in));
			end else if (addr_in == ardr_pkg::SECOND_DECEL_OFS) begin
				second_decel_time_setting <= clamp_time(DW'(wdata_in));
			end else if (addr_in == ardr_pkg::BASE_FREQ_OFS) begin
				base_frequency_setting <= wdata_in[FW-1:0];
			end else if (addr_in == ardr_pkg::PATTERN_OFS) begin
				if (wdata_in[ardr_pkg::PATTERN_W-1:0] <= ardr_pkg::PATTERN_S_B) begin
					ramp_pattern_select <= wdata_in[ardr_pkg::PATTERN_W-1:0];
				end
			end else if (addr_in == ardr_pkg::GAIN_A_OFS) begin
				gain_frequency_input_a <= wdata_in[FW-1:0];
			end else if (addr_in == ardr_pkg::GAIN_B_OFS) begin
				gain_frequency_input_b <= wdata_in[FW-1:0];
			end else if (addr_in == ardr_pkg::TARGET_FREQ_OFS) begin
				target_frequency <= (wdata_in > 32'(ardr_pkg::REF_FREQ_MAX)) ?
					ardr_pkg::REF_FREQ_MAX : wdata_in[FW-1:0];
			end
		end
	end

	// read port, data only in the cycle after the strobe
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			rdata_out <= '0;
		end else if (ce_in) begin
			rdata_out <= '0;
			if (rd_in) begin
				if (addr_in == ardr_pkg::ACCEL_TIME_OFS) begin
					rdata_out <= 32'(accel_time_setting);
				end else if (addr_in == ardr_pkg::DECEL_TIME_OFS) begin
					rdata_out <= 32'(decel_time_setting);
				end else if (addr_in == ardr_pkg::REF_FREQ_OFS) begin
					rdata_out <= 32'(ramp_reference_frequency);
				end else if (addr_in == ardr_pkg::SECOND_ACCEL_OFS) begin
					rdata_out <= 32'(second_accel_time_setting);
				end else if (addr_in == ardr_pkg::SECOND_DECEL_OFS) begin
					rdata_out <= 32'(second_decel_time_setting);
				end else if (addr_in == ardr_pkg::BASE_FREQ_OFS) begin
					rdata_out <= 32'(base_frequency_setting);
				end else if (addr_in == ardr_pkg::PATTERN_OFS) begin
					rdata_out <= 32'(ramp_pattern_select);
				end else if (addr_in == ardr_pkg::GAIN_A_OFS) begin
					rdata_out <= 32'(gain_frequency_input_a);
				end else if (addr_in == ardr_pkg::GAIN_B_OFS) begin
					rdata_out <= 32'(gain_frequency_input_b);
				end else if (addr_in == ardr_pkg::TARGET_FREQ_OFS) begin
					rdata_out <= 32'(target_frequency);
				end else if (addr_in == ardr_pkg::OUTPUT_FREQ_OFS) begin
					rdata_out <= 32'(output_frequency_out);
				end else if (addr_in == ardr_pkg::STATUS_OFS) begin
					rdata_out[ardr_pkg::STATUS_SEL_BIT] <= second_set_select;
					rdata_out[ardr_pkg::STATUS_UP_BIT] <= ramp_busy_out && ramp_up;
					rdata_out[ardr_pkg::STATUS_DOWN_BIT] <= ramp_busy_out && !ramp_up;
					rdata_out[ardr_pkg::STATUS_AT_TARGET_BIT] <= (freq_acc == target_acc);
				end
			end
		end
	end

	// fixed update tick
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			tick_cnt <= '0;
		end else if (ce_in) begin
			if (tick) begin
				tick_cnt <= '0;
			end else begin
				tick_cnt <= tick_cnt + 1'b1;
			end
		end
	end

	assign tick = (tick_cnt == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1));

	// active time selection, sampled fresh at each update
	always_comb begin
		sel_accel = second_set_select ? second_accel_time_setting : accel_time_setting;
		if (!second_set_select) begin
			sel_decel = decel_time_setting;
		end else if (second_decel_time_setting == ardr_pkg::SECOND_DECEL_FOLLOW) begin
			sel_decel = second_accel_time_setting;
		end else begin
			sel_decel = second_decel_time_setting;
		end
		raw_time = (target_acc > freq_acc) ? sel_accel : sel_decel;
		eff_time = (raw_time <= ardr_pkg::TIME_CLAMP_LIMIT) ? ardr_pkg::TIME_MIN : raw_time;
	end

	// step per tick = basis * 2^frac / (time * ticks per time unit)
	always_comb begin
		div_num = DW'(ramp_reference_frequency) << ardr_pkg::FRAC_W;
		div_den = DW'(eff_time) * DW'(ardr_pkg::TICKS_PER_TIME_UNIT);
		if (ramp_pattern_select == ardr_pkg::PATTERN_S_A) begin
			if (out_freq >= base_frequency_setting && out_freq != '0) begin
				div_num = (DW'(base_frequency_setting) * DW'(base_frequency_setting) *
					DW'(ardr_pkg::SA_NUM_FACTOR)) << ardr_pkg::FRAC_W;
				div_den = DW'(eff_time) * DW'(ardr_pkg::TICKS_PER_TIME_UNIT) *
					DW'(ardr_pkg::SA_DEN_FACTOR) * DW'(out_freq);
			end else begin
				div_num = DW'(base_frequency_setting) << ardr_pkg::FRAC_W;
			end
		end
	end

	assign div_start = (state == ardr_pkg::ARDR_IDLE) && tick && (target_acc != freq_acc);

	ardr_divider #(
		.W(DW)
	) u_div (
		.core_clk_in(core_clk_in),
		.rst_in(rst_in),
		.ce_in(ce_in),
		.start_in(div_start),
		.num_in(div_num),
		.den_in(div_den),
		.done_out(div_done),
		.quot_out(div_quot)
	);

	assign step = (div_quot > DW'({AW{1'b1}})) ? {AW{1'b1}} : div_quot[AW-1:0];
	assign next_up = {1'b0, freq_acc} + {1'b0, step};
	assign next_down = {1'b0, freq_acc} - {1'b0, step};

	// ramp state and frequency accumulator
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			state <= ardr_pkg::ARDR_IDLE;
			ramp_up <= 1'b0;
			freq_acc <= '0;
		end else if (ce_in) begin
			case (state)
				ardr_pkg::ARDR_IDLE: begin
					if (div_start) begin
						ramp_up <= target_acc > freq_acc;
						state <= ardr_pkg::ARDR_DIVIDE;
					end
				end
				ardr_pkg::ARDR_DIVIDE: begin
					if (div_done) begin
						state <= ardr_pkg::ARDR_IDLE;
						if (ramp_up) begin
							if (next_up >= {1'b0, target_acc}) begin
								freq_acc <= target_acc;
							end else begin
								freq_acc <= next_up[AW-1:0];
							end
						end else begin
							if (next_down[AW] || next_down <= {1'b0, target_acc}) begin
								freq_acc <= target_acc;
							end else begin
								freq_acc <= next_down[AW-1:0];
							end
						end
					end
				end
				default: state <= ardr_pkg::ARDR_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			output_frequency_out <= '0;
		end else if (ce_in) begin
			output_frequency_out <= out_freq;
		end
	end

	assign ramp_busy_out = (freq_acc != target_acc);
endmodule

/* File: ardr_pkg.sv */
package ardr_pkg;
	// register bus
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;
	localparam logic [7:0] ACCEL_TIME_OFS = 8'h00;
	localparam logic [7:0] DECEL_TIME_OFS = 8'h04;
	localparam logic [7:0] REF_FREQ_OFS = 8'h08;
	localparam logic [7:0] SECOND_ACCEL_OFS = 8'h0c;
	localparam logic [7:0] SECOND_DECEL_OFS = 8'h10;
	localparam logic [7:0] BASE_FREQ_OFS = 8'h14;
	localparam logic [7:0] PATTERN_OFS = 8'h18;
	localparam logic [7:0] GAIN_A_OFS = 8'h1c;
	localparam logic [7:0] GAIN_B_OFS = 8'h20;
	localparam logic [7:0] TARGET_FREQ_OFS = 8'h24;
	localparam logic [7:0] OUTPUT_FREQ_OFS = 8'h28;
	localparam logic [7:0] STATUS_OFS = 8'h2c;
	// field widths: times in 10 ms units, frequencies in 0.01 Hz units
	localparam int TIME_W = 19;
	localparam int FREQ_W = 16;
	localparam int PATTERN_W = 2;
	localparam int STATUS_SEL_BIT = 0;
	localparam int STATUS_UP_BIT = 1;
	localparam int STATUS_DOWN_BIT = 2;
	localparam int STATUS_AT_TARGET_BIT = 3;
	// reset values and limits
	localparam logic [18:0] TIME_RST = 19'h001f4;
	localparam logic [18:0] TIME_MAX = 19'h57e40;
	localparam logic [18:0] SECOND_DECEL_FOLLOW = 19'h0270f;
	localparam logic [18:0] TIME_CLAMP_LIMIT = 19'h00003;
	localparam logic [18:0] TIME_MIN = 19'h00004;
	localparam logic [15:0] REF_FREQ_RST = 16'h1770;
	localparam logic [15:0] REF_FREQ_MIN = 16'h0064;
	localparam logic [15:0] REF_FREQ_MAX = 16'h9c40;
	localparam logic [15:0] BASE_FREQ_RST = 16'h1770;
	localparam logic [15:0] GAIN_FREQ_RST = 16'h1770;
	localparam logic [15:0] TARGET_FREQ_RST = 16'h0000;
	localparam logic [1:0] PATTERN_RST = 2'h0;
	localparam logic [1:0] PATTERN_LINEAR = 2'h0;
	localparam logic [1:0] PATTERN_S_A = 2'h1;
	localparam logic [1:0] PATTERN_S_B = 2'h2;
	// timing
	localparam int CLK_HZ = 50000000;
	localparam int TICK_US = 1000;
	localparam int TIME_UNIT_US = 10000;
	localparam int TICK_CYCLES = CLK_HZ / 1000000 * TICK_US;
	localparam int TICKS_PER_TIME_UNIT = TIME_UNIT_US / TICK_US;
	localparam int FRAC_W = 16;
	localparam int DIV_W = 56;
	// S-pattern A law: slope above base is 9*fb^2 / (8*f*T)
	localparam int SA_NUM_FACTOR = 9;
	localparam int SA_DEN_FACTOR = 8;
	typedef enum logic [0:0] {ARDR_IDLE, ARDR_DIVIDE} ardr_state_t;
endpackage

/* File: ardr_divider.sv */
`timescale 1ns/1ps
module ardr_divider #(
	parameter int W = 56
) (
	// clock and control
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	// operands
	input wire logic start_in,
	input wire logic [W-1:0] num_in,
	input wire logic [W-1:0] den_in,
	// result
	output logic done_out,
	output logic [W-1:0] quot_out
);
	logic [W-1:0] rem;
	logic [W-1:0] den;
	logic [$clog2(W+1)-1:0] cnt;
	logic busy;
	logic [W:0] shifted;
	logic [W:0] diff;

	assign shifted = {rem, quot_out[W-1]};
	assign diff = shifted - {1'b0, den};

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			rem <= '0;
			den <= '0;
			quot_out <= '0;
			cnt <= '0;
			busy <= 1'b0;
			done_out <= 1'b0;
		end else if (ce_in) begin
			done_out <= 1'b0;
			if (start_in) begin
				rem <= '0;
				den <= den_in;
				quot_out <= num_in;
				cnt <= ($clog2(W+1))'(W);
				busy <= 1'b1;
			end else if (busy) begin
				// restoring step, one quotient bit per cycle
				if (!diff[W]) begin
					rem <= diff[W-1:0];
					quot_out <= {quot_out[W-2:0], 1'b1};
				end else begin
					rem <= shifted[W-1:0];
					quot_out <= {quot_out[W-2:0], 1'b0};
				end
				cnt <= cnt - 1'b1;
				if (cnt == 1) begin
					busy <= 1'b0;
					done_out <= 1'b1;
				end
			end
		end
	end
endmodule

/* File: ardr_ramp_checker.sv */
`timescale 1ns/1ps
module ardr_ramp_checker #(
	parameter int TICK_CYCLES = 100
) (
	// clock, reset and register port
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic [ardr_pkg::ADDR_W-1:0] addr_in,
	input wire logic [ardr_pkg::DATA_W-1:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire logic [ardr_pkg::DATA_W-1:0] rdata_out,
	// terminal and ramp outputs
	input wire logic second_set_select_in,
	input wire logic [ardr_pkg::FREQ_W-1:0] output_frequency_out,
	input wire logic second_function_active_out,
	input wire logic ramp_busy_out
);
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	property p_one_step_per_tick;
		$changed(output_frequency_out) |=> $stable(output_frequency_out)[*8];
	endproperty
	a_one_step_per_tick: assert property (p_one_step_per_tick) else $error("double step");
	property p_change_needs_busy;
		$changed(output_frequency_out) |-> $past(ramp_busy_out, 2);
	endproperty
	a_change_needs_busy: assert property (p_change_needs_busy) else $error("step while idle");
	property p_idle_holds;
		(!ramp_busy_out && !wr_in)[*3] |=> $stable(output_frequency_out);
	endproperty
	a_idle_holds: assert property (p_idle_holds) else $error("output moved at target");
	property p_select_on;
		second_set_select_in[*4] |=> second_function_active_out;
	endproperty
	a_select_on: assert property (p_select_on) else $error("second set not taken");
	property p_select_off;
		!second_set_select_in[*4] |=> !second_function_active_out;
	endproperty
	a_select_off: assert property (p_select_off) else $error("primary set not taken");
	property p_glitch_rejected;
		$rose(second_function_active_out) |-> $past(second_set_select_in, 3)
			&& $past(second_set_select_in, 4);
	endproperty
	a_glitch_rejected: assert property (p_glitch_rejected) else $error("glitch taken");
	property p_ref_range;
		rd_in && addr_in == ardr_pkg::REF_FREQ_OFS |=> rdata_out >= 32'h64 && rdata_out <= 32'h9c40;
	endproperty
	a_ref_range: assert property (p_ref_range) else $error("reference out of range");
	property p_time_range;
		rd_in && addr_in == ardr_pkg::ACCEL_TIME_OFS |=> rdata_out <= 32'h57e40;
	endproperty
	a_time_range: assert property (p_time_range) else $error("ramp time out of range");
	property p_pattern_range;
		rd_in && addr_in == ardr_pkg::PATTERN_OFS |=> rdata_out <= 32'h2;
	endproperty
	a_pattern_range: assert property (p_pattern_range) else $error("bad pattern code");
	cover property (second_set_select_in[*4] ##1 second_function_active_out);
	cover property ($fell(ramp_busy_out));
	cover property (rd_in && addr_in == ardr_pkg::OUTPUT_FREQ_OFS);
endmodule
bind ardr_ramp ardr_ramp_checker #(.TICK_CYCLES(TICK_CYCLES)) ardr_ramp_checker_inst (
	.core_clk_in(core_clk_in), .rst_in(rst_in), .ce_in(ce_in), .addr_in(addr_in),
	.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
	.second_set_select_in(second_set_select_in), .output_frequency_out(output_frequency_out),
	.second_function_active_out(second_function_active_out), .ramp_busy_out(ramp_busy_out)
);

/* File: ardr_terminal_model.sv */
`timescale 1ns/1ps
module ardr_terminal_model (
	// clock and requested contact level
	input wire logic core_clk_in,
	input wire logic request_in,
	// terminal assigned the second-set select function
	output logic terminal_out
);
	logic held = 1'b0;
	logic bounce = 1'b0;
	initial terminal_out = 1'b0;
	// contact bounce: new level, one inverted cycle, then steady
	always @(posedge core_clk_in) begin
		held <= request_in;
		bounce <= (request_in != held);
		terminal_out <= (request_in != held) ? request_in : (bounce ? ~held : held);
	end
endmodule

/* File: ardr_ramp_bench.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module ardr_ramp_bench;
	localparam int TICK = 100;
	logic core_clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic [ardr_pkg::ADDR_W-1:0] addr_in = 8'h00;
	logic [ardr_pkg::DATA_W-1:0] wdata_in = 32'h0;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic ce_in = 1'b1;
	logic sel_request = 1'b0;
	logic second_set_select_in;
	logic [ardr_pkg::DATA_W-1:0] rdata_out;
	logic [ardr_pkg::FREQ_W-1:0] output_frequency_out;
	logic second_function_active_out;
	logic ramp_busy_out;
	logic [31:0] got;
	int errors = 0;
	int n_compared = 0;
	initial forever #10 core_clk_in = ~core_clk_in;
	ardr_ramp #(.TICK_CYCLES(TICK)) ardr_ramp_inst (
		.core_clk_in(core_clk_in), .rst_in(rst_in), .ce_in(ce_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
		.second_set_select_in(second_set_select_in), .output_frequency_out(output_frequency_out),
		.second_function_active_out(second_function_active_out), .ramp_busy_out(ramp_busy_out));
	ardr_terminal_model ardr_terminal_model_inst (
		.core_clk_in(core_clk_in), .request_in(sel_request), .terminal_out(second_set_select_in));
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_in);
		wr_in <= 1'b1;
		addr_in <= a;
		wdata_in <= d;
		@(posedge core_clk_in);
		wr_in <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
		@(posedge core_clk_in);
		rd_in <= 1'b1;
		addr_in <= a;
		@(posedge core_clk_in);
		rd_in <= 1'b0;
		#1;
		got = rdata_out;
		`CHK(nm, e, got)
	endtask
	function automatic int lin_ticks(input int t, input int delta, input int basis);
		return 10 * ((t <= 3) ? 4 : t) * delta / basis;
	endfunction
	function automatic int sa_ticks(input longint t, input longint f, input longint fb);
		return int'(10 * t * (4 * f * f + 5 * fb * fb) / (9 * fb * fb) - 10 * t);
	endfunction
	task automatic ramp(input logic [15:0] tgt, input int ticks, input int tol);
		int cyc;
		cyc = 0;
		wr(ardr_pkg::TARGET_FREQ_OFS, {16'h0, tgt});
		#1;
		while (ramp_busy_out !== 1'b0 && cyc < 40000) begin
			@(posedge core_clk_in);
			#1;
			cyc++;
		end
		@(posedge core_clk_in);
		#1;
		`CHK("ramp length", 1'b1, 1'((cyc >= (ticks - tol) * TICK) && (cyc <= (ticks + tol) * TICK)))
		`CHK("final output frequency", tgt, output_frequency_out)
		`CHK("ramp busy at target", 1'b0, ramp_busy_out)
	endtask
	task automatic select(input logic lvl);
		@(posedge core_clk_in);
		sel_request <= lvl;
		repeat (10) @(posedge core_clk_in);
		#1;
		`CHK("second function active", lvl, second_function_active_out)
	endtask
	task automatic t_reset_values();
		logic [31:0] exp [12] = '{32'h1f4, 32'h1f4, 32'h1770, 32'h1f4, 32'h270f, 32'h1770,
			32'h0, 32'h1770, 32'h1770, 32'h0, 32'h0, 32'h8};
		for (int i = 0; i < 12; i++) begin
			rchk(8'(i * 4), exp[i], "reset value");
		end
		@(posedge core_clk_in);
		#1;
		`CHK("read data after its cycle", 32'h0, rdata_out)
		rchk(8'h40, 32'h0, "unmapped read");
		$display("test reset values done");
	endtask
	task automatic t_fields();
		wr(ardr_pkg::REF_FREQ_OFS, 32'h32);
		rchk(ardr_pkg::REF_FREQ_OFS, 32'h64, "reference low clamp");
		wr(ardr_pkg::REF_FREQ_OFS, 32'h1770);
		wr(ardr_pkg::ACCEL_TIME_OFS, 32'h57e40);
		rchk(ardr_pkg::ACCEL_TIME_OFS, 32'h57e40, "longest ramp time");
		for (int p = 0; p < 4; p++) begin
			wr(ardr_pkg::PATTERN_OFS, 32'(p));
			rchk(ardr_pkg::PATTERN_OFS, (p == 3) ? 32'h2 : 32'(p), "pattern code");
		end
		wr(ardr_pkg::PATTERN_OFS, 32'h0);
		$display("test register fields done");
	endtask
	task automatic t_linear();
		wr(ardr_pkg::ACCEL_TIME_OFS, 32'h3);
		ramp(16'h1770, lin_ticks(3, 6000, 6000), 2);
		wr(ardr_pkg::DECEL_TIME_OFS, 32'h5);
		ramp(16'h0, lin_ticks(5, 6000, 6000), 2);
		wr(ardr_pkg::ACCEL_TIME_OFS, 32'ha);
		ramp(16'h1770, lin_ticks(10, 6000, 6000), 2);
		$display("test linear ramps done");
	endtask
	task automatic t_second();
		select(1'b1);
		rchk(ardr_pkg::STATUS_OFS, 32'h9, "status with second set");
		wr(ardr_pkg::SECOND_ACCEL_OFS, 32'h8);
		ramp(16'h0, lin_ticks(8, 6000, 6000), 2);
		ramp(16'h1770, lin_ticks(8, 6000, 6000), 2);
		wr(ardr_pkg::SECOND_DECEL_OFS, 32'h4);
		ramp(16'h0bb8, lin_ticks(4, 3000, 6000), 2);
		wr(ardr_pkg::PATTERN_OFS, 32'h2);
		ramp(16'h1770, lin_ticks(8, 3000, 6000), 2);
		wr(ardr_pkg::PATTERN_OFS, 32'h0);
		select(1'b0);
		rchk(ardr_pkg::STATUS_OFS, 32'h8, "status with primary set");
		$display("test second set done");
	endtask
	task automatic t_ref();
		wr(ardr_pkg::REF_FREQ_OFS, 32'h2ee0);
		rchk(ardr_pkg::GAIN_A_OFS, 32'h1770, "gain a kept");
		rchk(ardr_pkg::GAIN_B_OFS, 32'h1770, "gain b kept");
		ramp(16'h0, lin_ticks(5, 6000, 12000), 2);
		ramp(16'h1770, lin_ticks(10, 6000, 12000), 2);
		$display("test reference frequency done");
	endtask
	task automatic t_s_pattern();
		wr(ardr_pkg::PATTERN_OFS, 32'h1);
		ramp(16'h2ee0, sa_ticks(10, 12000, 6000), 4);
		$display("test s pattern done");
	endtask
	task automatic t_freeze();
		wr(ardr_pkg::TARGET_FREQ_OFS, 32'h2710);
		repeat (500) @(posedge core_clk_in);
		ce_in <= 1'b0;
		@(posedge core_clk_in);
		#1;
		got = 32'(output_frequency_out);
		`CHK("ramp under way", 1'b1, 1'(got < 32'h2ee0))
		repeat (300) @(posedge core_clk_in);
		#1;
		`CHK("frozen output frequency", got, 32'(output_frequency_out))
		@(posedge core_clk_in);
		ce_in <= 1'b1;
		repeat (5000) @(posedge core_clk_in);
		#1;
		`CHK("output after freeze", 32'h2710, 32'(output_frequency_out))
		`CHK("settled after freeze", 1'b0, ramp_busy_out)
		$display("test clock enable done");
	endtask
	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge core_clk_in);
		rst_in <= 1'b0;
		t_reset_values();
		t_fields();
		t_linear();
		t_second();
		t_ref();
		t_s_pattern();
		t_freeze();
		finish_test();
	end
	initial begin
		repeat (90000) @(posedge core_clk_in);
		errors++;
		finish_test();
	end
endmodule
